// file: logic/rtc_alarm_match.sv
// equality compare of the alarm word against the visible count
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_match
  import rtc_pkg::*;
(
  input wire logic running_in,
  input wire count_word_t count_in,
  input wire count_word_t alarm_in,
  output logic match_out
);
  assign match_out = running_in && (count_in == alarm_in);
endmodule // rtc_alarm_match
`default_nettype wire

// file: logic/rtc_counter_with_alarm_wakeup.sv
// real-time clock: 47-bit counter, reload word, alarm compare and wake-up
// Summary of operation
// - 40-bit writable initial value register
// - writing run bit 1 starts counting
// - start copies initial value into count
// - start clears the 7-bit prescaler
// - counter advances once per oscillator cycle
// - low 15 bits overflow once per second
// - full overflow reloads initial value
// - stop, then restart begins fresh sequence
// - count readable at any time
// - alarm value in five byte registers
// - equal count and alarm sets flag
// - flag cleared only by software
// - wake request needs mode, enables, source
// - idle and slow-down do not stop counting
// - mode 3 keeps counting with oscillator
// - mode 1 with power-down bit stops clock; here mode 1 alone or the power-down bit alone stops counting
// - writes to count register are ignored
// - power-down bit resets to 0
// - flag sets only when irq enable 1
// - initial value write leaves count alone
`timescale 1ns/1ns
`default_nettype none
`include "rtc_regs.svh"
module rtc_counter_with_alarm_wakeup
  import rtc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [15:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic timekeeping_osc_in,
  output logic timekeeping_osc_out,
  input wire pd_mode_t pd_mode_in,
  input wire logic wake_from_powerdown_enable_in,
  input wire logic wake_source_select_in,
  output logic alarm_flag_out,
  output logic wake_request_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register byte decode

  function automatic logic [2:0] byte_sel(input logic [15:0] a,
                                          input logic [15:0] base);
    logic [15:0] d;
    d = a - base;
    byte_sel = d[2:0];
  endfunction

  function automatic logic in_block(input logic [15:0] a,
                                    input logic [15:0] base);
    in_block = (a >= base) && (a < base + 16'h0005);
  endfunction

  logic [7:0] init_value_reg [0:4];
  logic [7:0] alarm_compare_byte [0:4];
  logic run_control_bit;
  logic alarm_irq_enable;
  logic alarm_flag;
  logic clock_power_down_bit;
  run_state_t state;
  logic [`RTC_PRESCALE_W-1:0] prescaler;
  count_word_t count_value_reg;
  count_word_t read_snapshot;
  count_word_t init_word;
  count_word_t alarm_word;
  logic osc_level;
  logic osc_rise;
  logic alarm_match;
  logic ctrl_wr;
  logic start_req;
  logic stop_req;
  logic advance;
  logic full_overflow;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic [2:0] asel;
  logic ctrl_hit;
  logic init_hit;
  logic count_hit;
  logic alarm_hit;
  logic init_wr;
  logic alarm_wr;
  logic flag_set;
  logic flag_clear;
  logic load_now;
  logic running;
  logic mode_freeze;
  logic mode_wake;
  logic prescale_carry;

  // control, init and alarm decodes serve both write and read paths; count_hit only reads
  assign ctrl_hit = (addr_in == `RTC_CLOCK_CONTROL_ADDR);
  assign init_hit = in_block(addr_in, `RTC_INIT_VALUE_BASE);
  assign count_hit = in_block(addr_in, `RTC_COUNT_VALUE_BASE);
  assign alarm_hit = in_block(addr_in, `RTC_ALARM_COMPARE_BASE);
  // count bytes get no write strobe, so writes there vanish
  assign ctrl_wr = wr_en_in && ctrl_hit;
  assign init_wr = wr_en_in && init_hit;
  assign alarm_wr = wr_en_in && alarm_hit;
  assign wsel = byte_sel(addr_in, `RTC_INIT_VALUE_BASE);
  assign asel = byte_sel(addr_in, `RTC_ALARM_COMPARE_BASE);

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_bytes
      assign init_word[gi*8 +: 8] = init_value_reg[gi];
      assign alarm_word[gi*8 +: 8] = alarm_compare_byte[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // initial value and alarm byte registers

  // init writes only land in storage; count picks them up at load time
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < 5; i++) begin
        init_value_reg[i] <= `RTC_BYTE_RESET;
      end
    end else if (init_wr) begin
      init_value_reg[wsel] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < 5; i++) begin
        alarm_compare_byte[i] <= `RTC_BYTE_RESET;
      end
    end else if (alarm_wr) begin
      alarm_compare_byte[asel] <= wr_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  assign start_req = ctrl_wr && wr_data_in[`RTC_RUN_BIT] && !run_control_bit;
  assign stop_req = ctrl_wr && !wr_data_in[`RTC_RUN_BIT];

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      run_control_bit <= 1'b0;
    end else if (ctrl_wr) begin
      run_control_bit <= wr_data_in[`RTC_RUN_BIT];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      alarm_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      alarm_irq_enable <= wr_data_in[`RTC_IRQ_EN_BIT];
    end
  end

  // counting freezes but the run state survives a power-down
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      clock_power_down_bit <= 1'b0;
    end else if (ctrl_wr) begin
      clock_power_down_bit <= wr_data_in[`RTC_PD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm flag

  // writing a 1 to the flag bit is harmless, only a 0 clears it
  assign flag_set = alarm_match && alarm_irq_enable;
  assign flag_clear = ctrl_wr && !wr_data_in[`RTC_FLAG_BIT];

  // a match in the clearing cycle keeps the flag set
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      alarm_flag <= 1'b0;
    end else if (flag_set) begin
      alarm_flag <= 1'b1;
    end else if (flag_clear) begin
      alarm_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator sampling

  rtc_osc_sync u_osc_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .osc_in(timekeeping_osc_in),
    .level_out(osc_level),
    .rise_out(osc_rise)
  );

  // crystal feedback stays quiet while powered down
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      timekeeping_osc_out <= 1'b0;
    end else begin
      timekeeping_osc_out <= ~osc_level & ~clock_power_down_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run state and 47-bit counter

  assign load_now = (state == st_loading);
  assign running = (state == st_running);
  // mode 1 freezes the count; modes 2 and 3 may wake on an alarm
  assign mode_freeze = (pd_mode_in == pd_mode_one);
  assign mode_wake = (pd_mode_in == pd_mode_two)
                     || (pd_mode_in == pd_mode_three);

  // idle and slow-down are not inputs here, so nothing else can halt it
  assign advance = running && osc_rise && !clock_power_down_bit
                   && !mode_freeze;
  assign prescale_carry = advance && (&prescaler);
  assign full_overflow = prescale_carry && (&count_value_reg);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= st_stopped;
    end else begin
      unique case (state)
        st_stopped: begin
          if (start_req) begin
            state <= st_loading;
          end
        end
        st_loading: begin
          // a stop written in the load cycle wins over the start
          state <= stop_req ? st_stopped : st_running;
        end
        st_running: begin
          if (stop_req) begin
            state <= st_stopped;
          end
        end
        default: begin
          state <= st_stopped;
        end
      endcase
    end
  end

  // the low 7 bits are never visible; they only pace the count
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prescaler <= `RTC_PRESCALE_CLEAR;
    end else if (load_now || full_overflow) begin
      prescaler <= `RTC_PRESCALE_CLEAR;
    end else if (advance) begin
      prescaler <= prescaler + `RTC_PRESCALE_W'(1);
    end
  end

  // no write path reaches the count; only load, reload and advance
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_value_reg <= `RTC_WORD_RESET;
    end else if (load_now) begin
      count_value_reg <= init_word;
    end else if (full_overflow) begin
      count_value_reg <= init_word;
    end else if (prescale_carry) begin
      // bit 15 of the full count is bit 8 of the visible word: seconds
      count_value_reg <= count_value_reg + `RTC_COUNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm and wake-up

  rtc_alarm_match u_alarm_match (
    .running_in(running),
    .count_in(count_value_reg),
    .alarm_in(alarm_word),
    .match_out(alarm_match)
  );

  assign alarm_flag_out = alarm_flag;
  assign wake_request_out = alarm_flag && alarm_irq_enable
                            && wake_from_powerdown_enable_in
                            && wake_source_select_in
                            && mode_wake;

  ////////////////////////////////////////////////////////////////////////////
  // read port

  assign rsel = byte_sel(addr_in, `RTC_COUNT_VALUE_BASE);

  // lowest byte read freezes the upper bytes for the rest of the word
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      read_snapshot <= `RTC_WORD_RESET;
    end else if (rd_en_in && (addr_in == `RTC_COUNT_VALUE_BASE)) begin
      read_snapshot <= count_value_reg;
    end
  end

  // a byte read answers exactly one cycle later
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
    end
  end

  // upper count bytes come from the snapshot: read byte 0 first
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= `RTC_BYTE_RESET;
    end else if (!rd_en_in) begin
      rd_data_out <= rd_data_out;
    end else if (ctrl_hit) begin
      rd_data_out <= {4'h0, clock_power_down_bit, alarm_flag,
                      alarm_irq_enable, run_control_bit};
    end else if (init_hit) begin
      rd_data_out <= init_value_reg[wsel];
    end else if (count_hit) begin
      rd_data_out <= (rsel == 3'h0) ? count_value_reg[7:0]
                     : read_snapshot[rsel*8 +: 8];
    end else if (alarm_hit) begin
      rd_data_out <= alarm_compare_byte[asel];
    end else begin
      rd_data_out <= `RTC_BYTE_RESET;
    end
  end

endmodule // rtc_counter_with_alarm_wakeup
`default_nettype wire

// file: logic/rtc_osc_sync.sv
// two-stage synchroniser and rising-edge pulse for the timekeeping input
`timescale 1ns/1ns
`default_nettype none
module rtc_osc_sync (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic osc_in,
  output logic level_out,
  output logic rise_out
);
  logic stage_one;
  logic stage_two;
  logic stage_prev;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
      stage_prev <= 1'b0;
    end else begin
      stage_one <= osc_in;
      stage_two <= stage_one;
      stage_prev <= stage_two;
    end
  end

  // only the second stage feeds the edge detector
  assign level_out = stage_two;
  assign rise_out = stage_two & ~stage_prev;
endmodule // rtc_osc_sync
`default_nettype wire

// file: logic/rtc_pkg.sv
// types shared by the real-time clock design
package rtc_pkg;
  typedef enum logic [1:0] {
    pd_none = 2'h0,
    pd_mode_one = 2'h1,
    pd_mode_two = 2'h2,
    pd_mode_three = 2'h3
  } pd_mode_t;
  typedef enum logic [1:0] {
    st_stopped = 2'h0,
    st_loading = 2'h1,
    st_running = 2'h3
  } run_state_t;
  typedef logic [39:0] count_word_t;
endpackage

// file: logic/rtc_regs.svh
// register offsets, field positions and reset values of the real-time clock
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
`define RTC_ADDR_W 16
`define RTC_CLOCK_CONTROL_ADDR 16'hf3f0
`define RTC_INIT_VALUE_BASE 16'hf3f1
`define RTC_COUNT_VALUE_BASE 16'hf3f6
`define RTC_ALARM_COMPARE_BASE 16'hf3fb
`define RTC_BYTES_PER_REG 3'h5
`define RTC_RUN_BIT 0
`define RTC_IRQ_EN_BIT 1
`define RTC_FLAG_BIT 2
`define RTC_PD_BIT 3
`define RTC_BYTE_RESET 8'h00
`define RTC_PRESCALE_W 7
`define RTC_COUNT_W 40
`define RTC_FULL_W 47
`define RTC_PRESCALE_CLEAR 7'h00
`define RTC_WORD_RESET 40'h00_0000_0000
`endif

// file: verification/rtc_counter_with_alarm_wakeup_assertions.sv
// port-level assertions for the real-time clock
`timescale 1ns/1ns
`default_nettype none
module rtc_checker
  import rtc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [15:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic timekeeping_osc_out,
  input wire pd_mode_t pd_mode_in,
  input wire logic wake_from_powerdown_enable_in,
  input wire logic wake_source_select_in,
  input wire logic alarm_flag_out,
  input wire logic wake_request_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic ie_seen;
  logic pd_seen;
  logic ctl_wr;
  assign ctl_wr = wr_en_in && addr_in == 16'hf3f0;
  // shadow of control bits; only control writes move them
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ie_seen <= 1'b0;
      pd_seen <= 1'b0;
    end else if (ctl_wr) begin
      ie_seen <= wr_data_in[1];
      pd_seen <= wr_data_in[3];
    end
  end
  a_read_answered: assert property (rd_en_in |=> rd_valid_out)
    else $error("read not answered");
  a_valid_single: assert property (!rd_en_in |=> !rd_valid_out)
    else $error("read valid without read");
  a_unmapped_zero: assert property (rd_en_in && addr_in < 16'hf3f0
    |=> rd_data_out == 8'h00) else $error("unmapped read not zero");
  a_flag_sticky: assert property (alarm_flag_out &&
    !(ctl_wr && !wr_data_in[2]) |=> alarm_flag_out) else $error("flag lost");
  a_flag_needs_ie: assert property ($rose(alarm_flag_out)
    |-> $past(ie_seen)) else $error("flag set with enable off");
  a_wake_gated: assert property (wake_request_out |-> alarm_flag_out &&
    ie_seen && wake_from_powerdown_enable_in && wake_source_select_in &&
    pd_mode_in[1]) else $error("wake without all conditions");
  a_wake_given: assert property (alarm_flag_out && ie_seen &&
    wake_from_powerdown_enable_in && wake_source_select_in && pd_mode_in[1]
    |-> wake_request_out) else $error("wake missing");
  a_osc_quiet_pd: assert property (pd_seen && $past(pd_seen)
    |-> !timekeeping_osc_out) else $error("feedback on while powered down");
  a_reset_clears: assert property (disable iff (1'b0) rst_in
    |=> !rd_valid_out && !alarm_flag_out) else $error("reset left outputs");
  c_flag_rise: cover property ($rose(alarm_flag_out));
  c_wake: cover property (wake_request_out);
  c_count_read: cover property (rd_en_in && addr_in == 16'hf3f6);
endmodule // rtc_checker
bind rtc_counter_with_alarm_wakeup rtc_checker u_chk (.clock_in, .rst_in,
  .addr_in, .wr_en_in, .rd_en_in, .wr_data_in, .rd_data_out, .rd_valid_out,
  .timekeeping_osc_out, .pd_mode_in, .wake_from_powerdown_enable_in,
  .wake_source_select_in, .alarm_flag_out, .wake_request_out);
`default_nettype wire

// file: verification/rtc_counter_with_alarm_wakeup_tb.sv
// self-checking bench for the real-time clock
`timescale 1ns/1ns
`default_nettype none
`include "rtc_regs.svh"
module rtc_counter_with_alarm_wakeup_tb
  import rtc_pkg::*;
;
  localparam logic [15:0] ctl = `RTC_CLOCK_CONTROL_ADDR;
  localparam logic [15:0] ini = `RTC_INIT_VALUE_BASE;
  localparam logic [15:0] cnt = `RTC_COUNT_VALUE_BASE;
  localparam logic [15:0] alm = `RTC_ALARM_COMPARE_BASE;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [7:0] wr_data_in = 8'h00;
  logic [7:0] rd_data_out;
  logic rd_valid_out;
  logic timekeeping_osc_in = 1'b0;
  logic timekeeping_osc_out;
  pd_mode_t pd_mode_in = pd_none;
  logic wake_from_powerdown_enable_in = 1'b0;
  logic wake_source_select_in = 1'b0;
  logic alarm_flag_out;
  logic wake_request_out;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];
  count_word_t a_w;
  count_word_t r_w;
  rtc_counter_with_alarm_wakeup DUT (.clock_in, .rst_in, .addr_in,
    .wr_en_in, .rd_en_in, .wr_data_in, .rd_data_out, .rd_valid_out,
    .timekeeping_osc_in, .timekeeping_osc_out, .pd_mode_in,
    .wake_from_powerdown_enable_in, .wake_source_select_in,
    .alarm_flag_out, .wake_request_out);
  always #5 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr_in = a;
    wr_data_in = d;
    wr_en_in = 1'b1;
    @(negedge clock_in);
    wr_en_in = 1'b0;
  endtask
  // expected byte is queued at the request, compared when valid shows
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clock_in);
    addr_in = a;
    rd_en_in = 1'b1;
    exp_q.push_back(e);
    @(negedge clock_in);
    rd_en_in = 1'b0;
  endtask
  task automatic wrw(input logic [15:0] b, input count_word_t w);
    for (int i = 0; i < 5; i++) wr(b + 16'(i), w[8*i+:8]);
  endtask
  // byte0 first: it freezes the upper bytes for a consistent word
  task automatic rdw(input logic [15:0] b, input count_word_t w);
    for (int i = 0; i < 5; i++) rd(b + 16'(i), w[8*i+:8]);
  endtask
  // period of 8 clocks, well above the 3-clock synchroniser delay
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clock_in);
      timekeeping_osc_in = 1'b1;
      repeat (4) @(negedge clock_in);
      timekeeping_osc_in = 1'b0;
      repeat (3) @(negedge clock_in);
    end
    repeat (4) @(negedge clock_in);
  endtask
  task automatic start(input logic [7:0] d);
    wr(ctl, d);
    repeat (3) @(negedge clock_in);
  endtask
  always @(negedge clock_in) begin
    if (rd_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check("extra read", 8'h01, 8'h00);
      else check("read data", rd_data_out, exp_q.pop_front());
    end
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    a_w = count_word_t'({$urandom(87852), $urandom});
    r_w = count_word_t'({$urandom, $urandom});
    repeat (8) @(negedge clock_in);
    rst_in = 1'b0;
    rd(ctl, 8'h00);
    rdw(alm, 40'h0);
    rd(16'h1234, 8'h00);
    wrw(ini, 40'hff_ffff_fffe);
    rdw(ini, 40'hff_ffff_fffe);
    wrw(cnt, r_w);
    rdw(cnt, 40'h0);
    start(8'h01);
    rdw(cnt, 40'hff_ffff_fffe);
    tick(128);
    rdw(cnt, 40'hff_ffff_ffff);
    wrw(ini, r_w);
    rdw(cnt, 40'hff_ffff_ffff);
    tick(128);
    rdw(cnt, r_w);
    tick(64);
    wr(ctl, 8'h00);
    tick(4);
    start(8'h01);
    tick(64);
    rdw(cnt, r_w);
    tick(64);
    rdw(cnt, r_w + 40'h1);
    wrw(ini, a_w - 40'h1);
    wrw(alm, a_w);
    rdw(alm, a_w);
    wr(ctl, 8'h00);
    start(8'h03);
    check("flag", alarm_flag_out, 8'h00);
    wake_from_powerdown_enable_in = 1'b1;
    wake_source_select_in = 1'b1;
    tick(128);
    check("flag", alarm_flag_out, 8'h01);
    for (int m = 0; m < 4; m++) begin
      pd_mode_in = pd_mode_t'(m);
      @(negedge clock_in);
      check("wake", wake_request_out, 8'(m >= 2));
    end
    wake_source_select_in = 1'b0;
    @(negedge clock_in);
    check("wake", wake_request_out, 8'h00);
    tick(128);
    rdw(cnt, a_w + 40'h1);
    check("flag", alarm_flag_out, 8'h01);
    wr(ctl, 8'h03);
    @(negedge clock_in);
    check("flag", alarm_flag_out, 8'h00);
    rd(ctl, 8'h03);
    pd_mode_in = pd_mode_one;
    tick(128);
    rdw(cnt, a_w + 40'h1);
    pd_mode_in = pd_none;
    wr(ctl, 8'h0b);
    tick(128);
    rdw(cnt, a_w + 40'h1);
    rd(ctl, 8'h0b);
    check("osc out", timekeeping_osc_out, 8'h00);
    wr(ctl, 8'h03);
    tick(128);
    rdw(cnt, a_w + 40'h2);
    check("osc out", timekeeping_osc_out, 8'h01);
    wr(ctl, 8'h01);
    wrw(alm, a_w + 40'h2);
    repeat (2) @(negedge clock_in);
    check("flag", alarm_flag_out, 8'h00);
    wr(ctl, 8'h03);
    repeat (2) @(negedge clock_in);
    check("flag", alarm_flag_out, 8'h01);
    wr(ctl, 8'h03);
    @(negedge clock_in);
    check("flag", alarm_flag_out, 8'h01);
    check("wake", wake_request_out, 8'h00);
    repeat (3) @(negedge clock_in);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule // rtc_counter_with_alarm_wakeup_tb
`default_nettype wire
